// [hw/swioc_defines.vh]
// constants for the switching input/output conditioning block
`ifndef SWIOC_DEFINES_VH
`define SWIOC_DEFINES_VH
`define SWIOC_CLK_HZ        25000000
`define SWIOC_TICK_MS       1
`define SWIOC_TICK_CYC      ((`SWIOC_CLK_HZ / 1000) * `SWIOC_TICK_MS)
`define SWIOC_CHAR_OPEN     8'h2B
`define SWIOC_CHAR_CLOSE    8'h2D
`define SWIOC_ADDR_CTRL     8'h00
`define SWIOC_ADDR_IN0_T    8'h04
`define SWIOC_ADDR_IN0_P    8'h08
`define SWIOC_ADDR_IN1_T    8'h0C
`define SWIOC_ADDR_IN1_P    8'h10
`define SWIOC_ADDR_OUT0_T   8'h14
`define SWIOC_ADDR_OUT0_E   8'h18
`define SWIOC_ADDR_OUT1_T   8'h1C
`define SWIOC_ADDR_OUT1_E   8'h20
`define SWIOC_ADDR_REF      8'h24
`define SWIOC_ADDR_STATUS   8'h28
`define SWIOC_CTRL_RST      32'h0000_0000
`define SWIOC_RESP_OKAY     2'b00
`define SWIOC_RESP_SLVERR   2'b10
`endif

// [hw/swioc_top.v]
// switching input/output conditioning with an AXI4-Lite register file
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
`include "swioc_defines.vh"

module swioc_top #(
    parameter TICK_CYC = `SWIOC_TICK_CYC
) (
    input  wire        sys_clk,
    input  wire        nrst,
    input  wire [1:0]  trigger_input,
    output reg  [1:0]  switched_output,
    input  wire        rx_valid,
    input  wire [7:0]  rx_char,
    input  wire        decode_done,
    input  wire [31:0] decode_code,
    output reg         gate_open_q,
    output reg         send_no_read_string,
    output reg         send_code,
    output reg  [3:0]  event_pulse,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

////////////////////////////////////////////////////////////////////////////////
// register file
reg  [31:0] ctrl_q;
reg  [31:0] in_t_q   [0:1];
reg  [31:0] in_p_q   [0:1];
reg  [31:0] out_t_q  [0:1];
reg  [31:0] out_e_q  [0:1];
reg  [31:0] ref_q;
reg  [7:0]  wadr_q;
reg  [31:0] wdat_q;
reg  [3:0]  wstb_q;
reg         aw_have_q;
reg         w_have_q;
wire [31:0] status_w;
integer     k;

function [31:0] swioc_mask;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0]  be;
    integer b;
    begin
        swioc_mask = old_v;
        for (b = 0; b < 4; b = b + 1) begin
            if (be[b]) begin
                swioc_mask[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
    end
endfunction

function swioc_mapped;
    input [7:0] a;
    begin
        swioc_mapped = (a[1:0] == 2'b00) && (a <= `SWIOC_ADDR_STATUS);
    end
endfunction

always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `SWIOC_RESP_OKAY;
        aw_have_q     <= 1'b0;
        w_have_q      <= 1'b0;
        wadr_q        <= 8'h00;
        wdat_q        <= 32'h0000_0000;
        wstb_q        <= 4'h0;
        ctrl_q        <= `SWIOC_CTRL_RST;
        ref_q         <= 32'h0000_0000;
        for (k = 0; k < 2; k = k + 1) begin
            in_t_q[k]  <= 32'h0000_0000;
            in_p_q[k]  <= 32'h0000_0000;
            out_t_q[k] <= 32'h0000_0000;
            out_e_q[k] <= 32'h0000_0000;
        end
    end else begin
        s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
        s_axi_wready  <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            wadr_q    <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdat_q   <= s_axi_wdata;
            wstb_q   <= s_axi_wstrb;
        end
        if (aw_have_q && w_have_q) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= swioc_mapped(wadr_q) && (wadr_q != `SWIOC_ADDR_STATUS) ?
                            `SWIOC_RESP_OKAY : `SWIOC_RESP_SLVERR;
            if (wadr_q == `SWIOC_ADDR_CTRL) begin
                ctrl_q <= swioc_mask(ctrl_q, wdat_q, wstb_q);
            end else if (wadr_q == `SWIOC_ADDR_IN0_T) begin
                in_t_q[0] <= swioc_mask(in_t_q[0], wdat_q, wstb_q);
            end else if (wadr_q == `SWIOC_ADDR_IN0_P) begin
                in_p_q[0] <= swioc_mask(in_p_q[0], wdat_q, wstb_q);
            end else if (wadr_q == `SWIOC_ADDR_IN1_T) begin
                in_t_q[1] <= swioc_mask(in_t_q[1], wdat_q, wstb_q);
            end else if (wadr_q == `SWIOC_ADDR_IN1_P) begin
                in_p_q[1] <= swioc_mask(in_p_q[1], wdat_q, wstb_q);
            end else if (wadr_q == `SWIOC_ADDR_OUT0_T) begin
                out_t_q[0] <= swioc_mask(out_t_q[0], wdat_q, wstb_q);
            end else if (wadr_q == `SWIOC_ADDR_OUT0_E) begin
                out_e_q[0] <= swioc_mask(out_e_q[0], wdat_q, wstb_q);
            end else if (wadr_q == `SWIOC_ADDR_OUT1_T) begin
                out_t_q[1] <= swioc_mask(out_t_q[1], wdat_q, wstb_q);
            end else if (wadr_q == `SWIOC_ADDR_OUT1_E) begin
                out_e_q[1] <= swioc_mask(out_e_q[1], wdat_q, wstb_q);
            end else if (wadr_q == `SWIOC_ADDR_REF) begin
                ref_q <= swioc_mask(ref_q, wdat_q, wstb_q);
            end
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h0000_0000;
        s_axi_rresp   <= `SWIOC_RESP_OKAY;
    end else begin
        s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= swioc_mapped(s_axi_araddr) ? `SWIOC_RESP_OKAY : `SWIOC_RESP_SLVERR;
            if (s_axi_araddr == `SWIOC_ADDR_CTRL) begin
                s_axi_rdata <= ctrl_q;
            end else if (s_axi_araddr == `SWIOC_ADDR_IN0_T) begin
                s_axi_rdata <= in_t_q[0];
            end else if (s_axi_araddr == `SWIOC_ADDR_IN0_P) begin
                s_axi_rdata <= in_p_q[0];
            end else if (s_axi_araddr == `SWIOC_ADDR_IN1_T) begin
                s_axi_rdata <= in_t_q[1];
            end else if (s_axi_araddr == `SWIOC_ADDR_IN1_P) begin
                s_axi_rdata <= in_p_q[1];
            end else if (s_axi_araddr == `SWIOC_ADDR_OUT0_T) begin
                s_axi_rdata <= out_t_q[0];
            end else if (s_axi_araddr == `SWIOC_ADDR_OUT0_E) begin
                s_axi_rdata <= out_e_q[0];
            end else if (s_axi_araddr == `SWIOC_ADDR_OUT1_T) begin
                s_axi_rdata <= out_t_q[1];
            end else if (s_axi_araddr == `SWIOC_ADDR_OUT1_E) begin
                s_axi_rdata <= out_e_q[1];
            end else if (s_axi_araddr == `SWIOC_ADDR_REF) begin
                s_axi_rdata <= ref_q;
            end else if (s_axi_araddr == `SWIOC_ADDR_STATUS) begin
                s_axi_rdata <= status_w;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// 1 ms timebase
reg  [15:0] div_q;
reg         tick_q;
always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
        div_q  <= 16'h0000;
        tick_q <= 1'b0;
    end else if (div_q == TICK_CYC[15:0] - 16'h0001) begin
        div_q  <= 16'h0000;
        tick_q <= 1'b1;
    end else begin
        div_q  <= div_q + 16'h0001;
        tick_q <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// gate events and decode result (ctrl: bits 3:0 event bit of input 0, 7:4 input 1)
wire [1:0] in_act;
reg  [1:0] in_act_q;
reg        decoded_q;
wire [1:0] in_rise = in_act & ~in_act_q;
wire [1:0] in_fall = ~in_act & in_act_q;
wire       ser_open  = rx_valid && (rx_char == `SWIOC_CHAR_OPEN);
wire       ser_close = rx_valid && (rx_char == `SWIOC_CHAR_CLOSE);
wire [3:0] ev_in0 = ctrl_q[3:0];
wire [3:0] ev_in1 = ctrl_q[7:4];
// event 0 is reading-gate control: the conditioned input going active opens, going inactive closes
wire       g_open  = ser_open || (in_rise[0] && ev_in0[0]) || (in_rise[1] && ev_in1[0]);
wire       g_close = ser_close || (in_fall[0] && ev_in0[0]) || (in_fall[1] && ev_in1[0]);
wire       ref_match = decode_done && (decode_code == ref_q);

always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
        in_act_q            <= 2'b00;
        gate_open_q         <= 1'b0;
        decoded_q           <= 1'b0;
        send_no_read_string <= 1'b0;
        send_code           <= 1'b0;
        event_pulse         <= 4'h0;
    end else begin
        in_act_q            <= in_act;
        send_code           <= gate_open_q && decode_done;
        send_no_read_string <= gate_open_q && g_close && !decoded_q && !decode_done;
        event_pulse         <= ({4{in_rise[0]}} & ev_in0) | ({4{in_rise[1]}} & ev_in1);
        if (g_open && !gate_open_q) begin
            gate_open_q <= 1'b1;
            decoded_q   <= 1'b0;
        end else if (g_close) begin
            gate_open_q <= 1'b0;
        end else if (gate_open_q && decode_done) begin
            decoded_q <= 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// input conditioning; timing word: 7:0 debounce, 15:8 on-delay, 23:16 pulse,
// 31:24 off-delay; polarity word bit 0 inverts the input
localparam S_IDLE = 4'b0001;
localparam S_DEB  = 4'b0010;
localparam S_ON   = 4'b0100;
localparam S_ACT  = 4'b1000;
genvar gi;
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_in
        reg  [3:0] st_q;
        reg  [7:0] cnt_q;
        reg  [7:0] off_q;
        reg        act_q;
        wire       lvl  = trigger_input[gi] ^ in_p_q[gi][0];
        wire [7:0] deb  = in_t_q[gi][7:0];
        wire [7:0] dly  = in_t_q[gi][15:8];
        wire [7:0] dur  = in_t_q[gi][23:16];
        wire [7:0] offd = in_t_q[gi][31:24];
        assign in_act[gi] = act_q;
        always @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
                st_q  <= S_IDLE;
                cnt_q <= 8'h00;
                off_q <= 8'h00;
                act_q <= 1'b0;
            end else begin
                case (st_q)
                    S_IDLE: begin
                        act_q <= 1'b0;
                        cnt_q <= 8'h00;
                        if (lvl) begin
                            st_q <= S_DEB;
                        end
                    end
                    S_DEB: begin
                        if (!lvl) begin
                            st_q <= S_IDLE;
                        end else if (cnt_q >= deb) begin
                            st_q  <= S_ON;
                            cnt_q <= 8'h00;
                        end else if (tick_q) begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                    S_ON: begin
                        if (cnt_q >= dly) begin
                            st_q  <= S_ACT;
                            act_q <= 1'b1;
                            cnt_q <= 8'h00;
                            off_q <= 8'h00;
                        end else if (tick_q) begin
                            cnt_q <= cnt_q + 8'h01;
                        end
                    end
                    default: begin
                        if (dur != 8'h00) begin
                            if (tick_q) begin
                                cnt_q <= cnt_q + 8'h01;
                            end
                            if (cnt_q >= dur) begin
                                act_q <= 1'b0;
                                if (!lvl) begin
                                    st_q <= S_IDLE;
                                end
                            end
                        end else if (lvl) begin
                            off_q <= 8'h00;
                        end else if (off_q >= offd) begin
                            act_q <= 1'b0;
                            st_q  <= S_IDLE;
                        end else if (tick_q) begin
                            off_q <= off_q + 8'h01;
                        end
                    end
                endcase
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// outputs; timing word 15:0 pulse, 31:16 delay; event word 6:0 activation
// enables, 14:8 deactivation enables, 16 invert, 17 negative reference mode
// events: 0 gate open, 1 gate close, 2 decode, 3 no-read, 4 ref compare (activation only, bit 12 never deactivates),
// 5 input 0 active, 6 input 1 active
wire [1:0] out_lvl;
wire [6:0] ev_vec;
assign ev_vec[0] = g_open && !gate_open_q;
assign ev_vec[1] = g_close && gate_open_q;
assign ev_vec[2] = decode_done;
assign ev_vec[3] = gate_open_q && g_close && !decoded_q && !decode_done;
assign ev_vec[4] = 1'b0;
assign ev_vec[5] = in_rise[0];
assign ev_vec[6] = in_rise[1];
generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_out
        reg  [15:0] dcnt_q;
        reg  [15:0] pcnt_q;
        reg         pend_q;
        reg         on_q;
        wire        refev = decode_done && (out_e_q[gi][17] ? !ref_match : ref_match);
        wire        act   = |(ev_vec[6:0] & out_e_q[gi][6:0]) || (out_e_q[gi][4] && refev);
        wire        deact = |(ev_vec[6:0] & out_e_q[gi][14:8]);
        assign out_lvl[gi] = on_q;
        always @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
                dcnt_q <= 16'h0000;
                pcnt_q <= 16'h0000;
                pend_q <= 1'b0;
                on_q   <= 1'b0;
            end else if (deact && (pend_q || on_q)) begin
                pend_q <= 1'b0;
                on_q   <= 1'b0;
            end else if (act && !pend_q && !on_q) begin
                pend_q <= 1'b1;
                dcnt_q <= 16'h0000;
            end else if (pend_q) begin
                if (dcnt_q >= out_t_q[gi][31:16]) begin
                    pend_q <= 1'b0;
                    on_q   <= 1'b1;
                    pcnt_q <= 16'h0000;
                end else if (tick_q) begin
                    dcnt_q <= dcnt_q + 16'h0001;
                end
            end else if (on_q) begin
                if (pcnt_q >= out_t_q[gi][15:0]) begin
                    on_q <= 1'b0;
                end else if (tick_q) begin
                    pcnt_q <= pcnt_q + 16'h0001;
                end
            end
        end
    end
endgenerate

always @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
        switched_output <= 2'b00;
    end else begin
        switched_output <= out_lvl ^ {out_e_q[1][16], out_e_q[0][16]};
    end
end

assign status_w = {26'h0, decoded_q, gate_open_q, out_lvl, in_act};

endmodule // swioc_top

// [sim/swioc_sva.sv]
// protocol and timing checker bound to the conditioning block top
`timescale 1ns/10ps
`include "swioc_defines.vh"
module swioc_sva #(
    parameter TICK_CYC = `SWIOC_TICK_CYC
) (
    input wire        sys_clk,
    input wire        nrst,
    input wire        rx_valid,
    input wire [7:0]  rx_char,
    input wire        decode_done,
    input wire        gate_open_q,
    input wire        send_no_read_string,
    input wire        send_code,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready
);
    reg seen_q;
    reg seen_d;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // remembers a decode inside the current gate, so a close can be judged
    always @* begin
        seen_d = seen_q;
        if (!gate_open_q)
            seen_d = 1'b0;
        if (decode_done && gate_open_q)
            seen_d = 1'b1;
    end
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            seen_q <= 1'b0;
        else
            seen_q <= seen_d;
    end
    sequence open_cmd;
        rx_valid && rx_char == `SWIOC_CHAR_OPEN;
    endsequence
    sequence close_cmd;
        rx_valid && rx_char == `SWIOC_CHAR_CLOSE && gate_open_q;
    endsequence
    gate_open_a: assert property (open_cmd |=> gate_open_q)
        else $error("gate did not open on open character");
    gate_close_a: assert property (close_cmd |=> !gate_open_q)
        else $error("gate did not close on close character");
    code_send_a: assert property (decode_done && gate_open_q |=> send_code)
        else $error("decode in open gate sent no code");
    no_read_a: assert property ((close_cmd and !seen_q && !decode_done)
        |=> ##[0:1] send_no_read_string) else $error("empty gate sent no no-read string");
    no_read_pulse_a: assert property (send_no_read_string |=> !send_no_read_string)
        else $error("no-read request longer than one cycle");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not next cycle");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    unmapped_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h28
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("unmapped read");
endmodule // swioc_sva

bind swioc_top swioc_sva #(.TICK_CYC(TICK_CYC)) i_sva (
    .sys_clk(sys_clk), .nrst(nrst), .rx_valid(rx_valid), .rx_char(rx_char),
    .decode_done(decode_done), .gate_open_q(gate_open_q),
    .send_no_read_string(send_no_read_string), .send_code(send_code),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));

// [sim/swioc_field.sv]
// far-side model: trigger sensor on the inputs, timed load on the outputs
`timescale 1ns/10ps
module swioc_field (
    input  wire       sys_clk,
    output reg  [1:0] trigger_input,
    input  wire [1:0] switched_output
);
    reg  [1:0] idle_lvl = 2'b00;
    reg  [1:0] on_q     = 2'b00;
    integer    hold    [0:1] = '{0, 0};
    integer    npulse  [0:1] = '{0, 0};
    integer    rise_at [0:1] = '{0, 0};
    integer    width   [0:1] = '{0, 0};
    integer    cyc = 0;
    integer    i;
    initial trigger_input = 2'b00;
    task press(input integer ch, input integer n);
        hold[ch] = n;
    endtask
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        for (i = 0; i < 2; i = i + 1) begin
            // a clean contact: no bounce, so debounce is tested by pulse length only
            trigger_input[i] <= idle_lvl[i] ^ (hold[i] > 0);
            if (hold[i] > 0)
                hold[i] <= hold[i] - 1;
            if (switched_output[i] === 1'b1 && !on_q[i]) begin
                on_q[i] <= 1'b1;
                rise_at[i] <= cyc;
            end
            if (switched_output[i] !== 1'b1 && on_q[i]) begin
                on_q[i] <= 1'b0;
                width[i] <= cyc - rise_at[i];
                npulse[i] <= npulse[i] + 1;
            end
        end
    end
endmodule // swioc_field

// [sim/swioc_bench.sv]
// self-checking bench: register access, serial gate, input and output timing
`timescale 1ns/10ps
`include "swioc_defines.vh"
module swioc_bench;
    reg         sys_clk = 1'b0;
    reg         nrst = 1'b0;
    wire [1:0]  trigger_input;
    wire [1:0]  switched_output;
    reg         rx_valid = 1'b0;
    reg  [7:0]  rx_char = 8'h00;
    reg         decode_done = 1'b0;
    reg  [31:0] decode_code = 32'h0;
    wire        gate_open_q, send_no_read_string, send_code;
    wire [3:0]  event_pulse;
    reg  [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg  [31:0] s_axi_wdata = 32'h0;
    reg         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    reg         s_axi_arvalid = 0, s_axi_rready = 0;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    integer     fails = 0, total_checks = 0, tmo = 0, nr_cnt = 0, sc_cnt = 0, ep_cnt = 0, n, t0, k;
    localparam [1:0] OK = `SWIOC_RESP_OKAY, ERR = `SWIOC_RESP_SLVERR;
    localparam [31:0] REFV = 32'h1234_ABCD;
    always #20 sys_clk = ~sys_clk;
    swioc_top #(.TICK_CYC(4)) i_dut (.sys_clk(sys_clk), .nrst(nrst),
        .trigger_input(trigger_input), .switched_output(switched_output),
        .rx_valid(rx_valid), .rx_char(rx_char), .decode_done(decode_done),
        .decode_code(decode_code), .gate_open_q(gate_open_q),
        .send_no_read_string(send_no_read_string), .send_code(send_code),
        .event_pulse(event_pulse), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    swioc_field i_field (.sys_clk(sys_clk), .trigger_input(trigger_input),
        .switched_output(switched_output));
    ////////////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task axw(input [7:0] a, input [31:0] d, input [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge sys_clk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
        @(posedge sys_clk);
    endtask
    // rready comes one cycle late so the slave has to hold its answer
    task axr(input [7:0] a, input [31:0] exp, input [1:0] er);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        @(posedge sys_clk);
        s_axi_rready <= 1'b1;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk(s_axi_rresp, er);
        chk(s_axi_rdata, exp);
        @(posedge sys_clk);
    endtask
    task rx(input [7:0] c);
        rx_char <= c;
        rx_valid <= 1'b1;
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask
    task dec(input [31:0] c);
        decode_code <= c;
        decode_done <= 1'b1;
        @(posedge sys_clk);
        decode_done <= 1'b0;
        repeat (20) @(posedge sys_clk);
    endtask
    task wait_gate(input lvl);
        n = 0;
        while (gate_open_q !== lvl && n < 200) begin
            @(posedge sys_clk);
            n = n + 1;
        end
    endtask
    always @(posedge sys_clk) begin
        tmo <= tmo + 1;
        if (send_no_read_string === 1'b1) nr_cnt <= nr_cnt + 1;
        if (send_code === 1'b1) sc_cnt <= sc_cnt + 1;
        if (event_pulse[0] === 1'b1) ep_cnt <= ep_cnt + 1;
        if (tmo > 30000) begin
            fails = fails + 1;
            stop_test;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        axr(`SWIOC_ADDR_CTRL, `SWIOC_CTRL_RST, OK);
        axr(8'h3C, 32'h0, ERR);
        axw(`SWIOC_ADDR_STATUS, 32'hFFFF_FFFF, ERR);
        axw(`SWIOC_ADDR_REF, REFV, OK);
        axr(`SWIOC_ADDR_REF, REFV, OK);
        // serial gate control and gate-end reporting
        rx(`SWIOC_CHAR_OPEN);
        chk(gate_open_q, 1);
        k = nr_cnt;
        rx(`SWIOC_CHAR_CLOSE);
        chk(gate_open_q, 0);
        chk(nr_cnt, k + 1);
        k = sc_cnt;
        rx(`SWIOC_CHAR_OPEN);
        dec(32'h55);
        chk(sc_cnt, k + 1);
        k = nr_cnt;
        rx(`SWIOC_CHAR_CLOSE);
        chk(nr_cnt, k);
        // input 0 opens the gate: debounce 2, on-delay 1, pulse 3 ms of 4 cycles
        axw(`SWIOC_ADDR_CTRL, 32'h1, OK);
        axw(`SWIOC_ADDR_IN0_T, 32'h0003_0102, OK);
        i_field.press(0, 4);
        repeat (10) @(posedge sys_clk);
        chk(gate_open_q, 0);
        k = ep_cnt;
        i_field.press(0, 60);
        wait_gate(1);
        chk(n >= 10 && n <= 18, 1);
        wait_gate(0);
        chk(n >= 9 && n <= 15, 1);
        chk(ep_cnt, k + 1);
        repeat (60) @(posedge sys_clk);
        chk(gate_open_q, 0);
        axw(`SWIOC_ADDR_IN0_T, 32'h0200_0000, OK);
        i_field.press(0, 8);
        wait_gate(1);
        wait_gate(0);
        chk(n >= 10 && n <= 16, 1);
        i_field.idle_lvl[0] = 1'b1;
        axw(`SWIOC_ADDR_IN0_P, 32'h1, OK);
        repeat (40) @(posedge sys_clk);
        chk(gate_open_q, 0);
        i_field.press(0, 8);
        wait_gate(1);
        chk(n < 12, 1);
        wait_gate(0);
        axw(`SWIOC_ADDR_CTRL, 32'h10, OK);
        axw(`SWIOC_ADDR_IN1_T, 32'h0002_0001, OK);
        repeat (40) @(posedge sys_clk);
        i_field.press(1, 30);
        wait_gate(1);
        wait_gate(0);
        chk(n >= 5 && n <= 11, 1);
        // output 0: delay 2, pulse 5 ms on gate open or decode
        axw(`SWIOC_ADDR_CTRL, 32'h0, OK);
        axw(`SWIOC_ADDR_OUT0_T, 32'h0002_0005, OK);
        axw(`SWIOC_ADDR_OUT0_E, 32'h5, OK);
        k = i_field.npulse[0];
        t0 = i_field.cyc;
        rx(`SWIOC_CHAR_OPEN);
        repeat (50) @(posedge sys_clk);
        chk(i_field.npulse[0], k + 1);
        chk(i_field.rise_at[0] - t0 >= 8 && i_field.rise_at[0] - t0 <= 14, 1);
        chk(i_field.width[0] >= 18 && i_field.width[0] <= 22, 1);
        rx(`SWIOC_CHAR_CLOSE);
        dec(32'h77);
        repeat (30) @(posedge sys_clk);
        chk(i_field.npulse[0], k + 2);
        axw(`SWIOC_ADDR_OUT0_E, 32'h205, OK);
        rx(`SWIOC_CHAR_OPEN);
        repeat (12) @(posedge sys_clk);
        rx(`SWIOC_CHAR_CLOSE);
        repeat (40) @(posedge sys_clk);
        chk(i_field.width[0] < 12, 1);
        // output 1 on reference compare, positive then negative
        axw(`SWIOC_ADDR_OUT1_T, 32'h1, OK);
        axw(`SWIOC_ADDR_OUT1_E, 32'h10, OK);
        k = i_field.npulse[1];
        dec(REFV);
        dec(REFV ^ 32'h1);
        chk(i_field.npulse[1], k + 1);
        axw(`SWIOC_ADDR_OUT1_E, 32'h2_0010, OK);
        dec(REFV ^ 32'h1);
        dec(REFV);
        chk(i_field.npulse[1], k + 2);
        axw(`SWIOC_ADDR_OUT1_E, 32'h1_0010, OK);
        repeat (4) @(posedge sys_clk);
        chk(switched_output[1], 1);
        stop_test;
    end
endmodule // swioc_bench
